// ---- design/rimx_pkg.sv ----
// Operation
// RULE1: opcode 0010_11dr_rrrr decrements register into destination, flags untouched.
// RULE2: decremented zero skips next instruction, pc plus two over two cycles.
// RULE3: five-bit register number and destination bit; clear means working register.
// RULE4: opcode 0010_10dr_rrrr increments into destination, updates zero flag, pc plus one.
// RULE5: opcode 0011_11dr_rrrr increments into destination, flags untouched.
// RULE6: incremented zero skips next instruction, pc plus two over two cycles.
// RULE7: opcode 0010_00dr_rrrr copies register to destination, pc plus one.
// RULE8: register copy updates zero flag; self copy keeps contents.
// RULE9: opcode 0000_001r_rrrr stores working register into register, flags untouched.
// RULE10: opcode 1100_vvvv_vvvv loads immediate into working register, flags untouched.
// RULE11: opcode 0000_0000_0vvv writes working register to port control 5, 6 or 7.
// RULE12: after port control write, pc advances by one.
// RULE13: skipped instruction is discarded with no side effects.
package rimx_pkg;
	localparam int DATA_W  = 8;
	localparam int INSTR_W = 12;
	localparam int PC_W    = 11;
	localparam int REG_N   = 32;
	localparam int RNUM_W  = 5;
	// opcode field positions
	localparam int DEST_BIT  = 5;
	localparam int RNUM_LSB  = 0;
	localparam int TOP6_LSB  = 6;
	localparam int TOP4_LSB  = 8;
	localparam int PSEL_W    = 3;
	// opcode patterns
	localparam logic [5:0] OP_DEC_SKIP = 6'h0b; // 0010_11
	localparam logic [5:0] OP_INC      = 6'h0a; // 0010_10
	localparam logic [5:0] OP_INC_SKIP = 6'h0f; // 0011_11
	localparam logic [5:0] OP_COPY     = 6'h08; // 0010_00
	localparam logic [6:0] OP_STORE    = 7'h01; // 0000_001
	localparam logic [3:0] OP_LOADI    = 4'hc;  // 1100
	localparam logic [8:0] OP_PORTW    = 9'h000; // 0000_0000_0
	localparam logic [2:0] PSEL_FIRST  = 3'h5;
	localparam logic [2:0] PSEL_SECOND = 3'h6;
	localparam logic [2:0] PSEL_THIRD  = 3'h7;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
	localparam logic [PC_W-1:0]   PC_STEP   = 11'h001;
	localparam logic [PC_W-1:0]   PC_RESET  = 11'h000;

	typedef enum logic [1:0] {
		RIMX_EXEC = 2'b01,
		RIMX_SKIP = 2'b10
	} rimx_state_e;
endpackage : rimx_pkg

// ---- design/rimx_decode.sv ----
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// combinational op-code decoder
// ------------------------------------------------
module rimx_decode
	import rimx_pkg::*;
(
	input  wire logic [INSTR_W-1:0] instr_in,
	output logic                    dec_skip_out,
	output logic                    inc_out,
	output logic                    inc_skip_out,
	output logic                    copy_out,
	output logic                    store_out,
	output logic                    loadi_out,
	output logic                    portw_out,
	output logic                    dest_reg_out,
	output logic [RNUM_W-1:0]       rnum_out
);
	// field matching
	always_comb begin
		dec_skip_out = instr_in[INSTR_W-1:TOP6_LSB] == OP_DEC_SKIP; // RULE1
		inc_out      = instr_in[INSTR_W-1:TOP6_LSB] == OP_INC;      // RULE4
		inc_skip_out = instr_in[INSTR_W-1:TOP6_LSB] == OP_INC_SKIP; // RULE5
		copy_out     = instr_in[INSTR_W-1:TOP6_LSB] == OP_COPY;     // RULE7
		store_out    = instr_in[INSTR_W-1:DEST_BIT] == OP_STORE;    // RULE9
		loadi_out    = instr_in[INSTR_W-1:TOP4_LSB] == OP_LOADI;    // RULE10
		portw_out    = instr_in[INSTR_W-1:PSEL_W] == OP_PORTW;      // RULE11
		dest_reg_out = instr_in[DEST_BIT];                          // RULE3
		rnum_out     = instr_in[RNUM_LSB +: RNUM_W];                // RULE3
	end
endmodule : rimx_decode
`default_nettype wire

// ---- design/rimx_exec.sv ----
`timescale 1ns/100ps
`default_nettype none
module rimx_exec
	import rimx_pkg::*;
(
	input  wire logic                 clk_sys_in,
	input  wire logic                 rst_b_in,
	input  wire logic                 clk_en_in,
	input  wire logic [INSTR_W-1:0]   instr_in,
	output logic      [PC_W-1:0]      pc_out,
	output logic      [DATA_W-1:0]    working_register_out,
	output logic                      zero_flag_out,
	output logic                      skip_cycle_out,
	output logic      [DATA_W-1:0]    port_control_first_out,
	output logic      [DATA_W-1:0]    port_control_second_out,
	output logic      [DATA_W-1:0]    port_control_third_out,
	output logic      [DATA_W-1:0]    reg_rd_out
);
	import rimx_pkg::*;

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	// zero test shared by flag update and skip decision
	function automatic logic rimx_is_zero(
		input logic [DATA_W-1:0] val
	);
		rimx_is_zero = (val == DATA_ZERO);
	endfunction : rimx_is_zero

	// sequential program counter advance, wraps at the top
	function automatic logic [PC_W-1:0] rimx_step_pc(
		input logic [PC_W-1:0] pc
	);
		rimx_step_pc = pc + PC_STEP;
	endfunction : rimx_step_pc

	// port control slot match for one select code
	function automatic logic rimx_psel_hit(
		input logic [PSEL_W-1:0] sel,
		input logic [PSEL_W-1:0] code
	);
		rimx_psel_hit = (sel == code);
	endfunction : rimx_psel_hit

	// ------------------------------------------------
	// state
	// ------------------------------------------------
	// whole core state in one packed word
	// register file is local, no special entries
	// enable low holds every field, skip cycle included
	typedef struct packed {
		rimx_state_e                  state;
		logic [PC_W-1:0]              pc;
		logic [DATA_W-1:0]            work;
		logic                         zero;
		logic [2:0][DATA_W-1:0]       portc;
		logic [REG_N-1:0][DATA_W-1:0] rf;
	} rimx_state_s;

	rimx_state_s st_reg;
	rimx_state_s st_next;

	logic              d_dec_skip;
	logic              d_inc;
	logic              d_inc_skip;
	logic              d_copy;
	logic              d_store;
	logic              d_loadi;
	logic              d_portw;
	logic              d_dest_reg;
	logic [RNUM_W-1:0] d_rnum;

	// ------------------------------------------------
	// decode
	// ------------------------------------------------
	rimx_decode u_decode (
		.instr_in     (instr_in),
		.dec_skip_out (d_dec_skip),
		.inc_out      (d_inc),
		.inc_skip_out (d_inc_skip),
		.copy_out     (d_copy),
		.store_out    (d_store),
		.loadi_out    (d_loadi),
		.portw_out    (d_portw),
		.dest_reg_out (d_dest_reg),
		.rnum_out     (d_rnum)
	);

	// ------------------------------------------------
	// execute
	// ------------------------------------------------
	// next-state computation for one cycle
	always_comb begin
		logic [DATA_W-1:0] src;
		logic [DATA_W-1:0] res;
		logic              wr;
		logic [PSEL_W-1:0] psel;
		src     = DATA_ZERO;
		res     = DATA_ZERO;
		wr      = 1'b0;
		psel    = instr_in[PSEL_W-1:0];
		st_next = st_reg;
		// operand read from the addressed entry, even when unused
		src = st_reg.rf[d_rnum];
		case (st_reg.state)
			RIMX_SKIP: begin
				// fetched word discarded, only pc and state move
				// no register, flag or port may change here
				st_next.pc    = rimx_step_pc(st_reg.pc); // RULE13
				st_next.state = RIMX_EXEC;               // RULE13
			end
			RIMX_EXEC: begin
				// every executed word moves on by one, skips add a cycle
				st_next.pc = rimx_step_pc(st_reg.pc); // RULE12
				if (d_dec_skip) begin
					// count down, flags untouched, skip on zero result
					res = src - DATA_ONE; // RULE1
					wr  = 1'b1;
					if (rimx_is_zero(res)) begin
						st_next.state = RIMX_SKIP; // RULE2
					end
				end else if (d_inc || d_inc_skip) begin
					// both count-up forms share the adder
					res = src + DATA_ONE; // RULE5
					wr  = 1'b1;
					if (d_inc) begin
						// plain increment reports zero, never skips
						st_next.zero = rimx_is_zero(res); // RULE4
					end else if (rimx_is_zero(res)) begin
						// skip form leaves the flag alone
						st_next.state = RIMX_SKIP; // RULE6
					end
				end else if (d_copy) begin
					// self copy rewrites the same value, only the flag moves
					res          = src; // RULE7
					wr           = 1'b1;
					st_next.zero = rimx_is_zero(res); // RULE8
				end else if (d_store) begin
					// working value into the file, flags untouched
					st_next.rf[d_rnum] = st_reg.work; // RULE9
				end else if (d_loadi) begin
					// immediate lands in the working register only
					st_next.work = instr_in[DATA_W-1:0]; // RULE10
				end else if (d_portw) begin
					// select codes outside the three slots do nothing
					if (rimx_psel_hit(psel, PSEL_FIRST)) begin
						st_next.portc[0] = st_reg.work; // RULE11
					end else if (rimx_psel_hit(psel, PSEL_SECOND)) begin
						st_next.portc[1] = st_reg.work; // RULE11
					end else if (rimx_psel_hit(psel, PSEL_THIRD)) begin
						st_next.portc[2] = st_reg.work; // RULE11
					end
				end
				// destination select for the read-modify-write forms
				if (wr) begin
					if (d_dest_reg) begin
						st_next.rf[d_rnum] = res; // RULE3
					end else begin
						st_next.work = res; // RULE3
					end
				end
			end
			default: begin
				// illegal state code recovers to normal execution
				st_next.state = RIMX_EXEC;
			end
		endcase
	end

	// ------------------------------------------------
	// registers
	// ------------------------------------------------
	// state register with enable
	// reset wins over a low enable, so one edge always clears
	// a low enable freezes a pending skip as well
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			st_reg       <= '0;
			st_reg.state <= RIMX_EXEC;
			st_reg.pc    <= PC_RESET;
		end else if (clk_en_in) begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------
	// outputs
	// ------------------------------------------------
	// outputs from state, all but the read port and the skip flag straight from flip-flops
	// read port follows the register field of the current word
	assign pc_out                  = st_reg.pc;
	assign working_register_out    = st_reg.work;
	assign zero_flag_out           = st_reg.zero;
	assign skip_cycle_out          = st_reg.state == RIMX_SKIP;
	assign port_control_first_out  = st_reg.portc[0];
	assign port_control_second_out = st_reg.portc[1];
	assign port_control_third_out  = st_reg.portc[2];
	assign reg_rd_out              = st_reg.rf[d_rnum];
endmodule : rimx_exec
`default_nettype wire

// ---- dv/rimx_exec_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
// ---------------------------
// execution checks
// ---------------------------
module rimx_exec_properties
	import rimx_pkg::*;
(
	input wire logic	clk_sys_in,
	input wire logic	rst_b_in,
	input wire logic	clk_en_in,
	input wire logic [INSTR_W-1:0]	instr_in,
	input wire logic [PC_W-1:0]	pc_out,
	input wire logic [DATA_W-1:0]	working_register_out,
	input wire logic	zero_flag_out,
	input wire logic	skip_cycle_out,
	input wire logic [DATA_W-1:0]	reg_rd_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	// executing edge and top op-code field
	wire	ex = clk_en_in && !skip_cycle_out;
	wire [5:0]	t6 = instr_in[11:6];
	a_dec_flag_hold: assert property (ex && t6 == OP_DEC_SKIP |=> $stable(zero_flag_out))
		else $error("count down changed zero flag");
	a_dec_skip_taken: assert property (ex && t6 == OP_DEC_SKIP
		|=> skip_cycle_out == ($past(reg_rd_out) == DATA_ONE)) else $error("count down skip wrong");
	a_inc_zero_flag: assert property (ex && t6 == OP_INC
		|=> zero_flag_out == ($past(reg_rd_out) == 8'hff)) else $error("increment zero wrong");
	a_inc_skip_taken: assert property (ex && t6 == OP_INC_SKIP
		|=> skip_cycle_out == ($past(reg_rd_out) == 8'hff)) else $error("count up skip wrong");
	a_copy_zero_flag: assert property (ex && t6 == OP_COPY
		|=> zero_flag_out == ($past(reg_rd_out) == DATA_ZERO)) else $error("copy zero wrong");
	a_load_imm_value: assert property (ex && instr_in[11:8] == OP_LOADI
		|=> working_register_out == $past(instr_in[7:0]) && $stable(zero_flag_out))
		else $error("immediate load wrong");
	a_pc_step: assert property (clk_en_in |=> pc_out == $past(pc_out) + PC_STEP)
		else $error("pc step wrong");
	a_skip_discard: assert property (skip_cycle_out && clk_en_in
		|=> !skip_cycle_out && $stable(working_register_out) && $stable(zero_flag_out))
		else $error("skip cycle had effect");
	c_dec_skip: cover property (ex && t6 == OP_DEC_SKIP && reg_rd_out == DATA_ONE);
	c_inc_skip: cover property (ex && t6 == OP_INC_SKIP && reg_rd_out == 8'hff);
	c_copy: cover property (ex && t6 == OP_COPY);
endmodule : rimx_exec_properties
bind rimx_exec rimx_exec_properties i_rimx_exec_properties (.*);
`default_nettype wire

// ---- dv/rimx_prog_mem.sv ----
`timescale 1ns/100ps
`default_nettype none
// ---------------------------
// program memory model
// ---------------------------
module rimx_prog_mem
	import rimx_pkg::*;
(
	input wire logic	clk_sys_in,
	input wire logic	load_in,
	input wire logic [PC_W-1:0]	addr_in,
	input wire logic [INSTR_W-1:0]	data_in,
	input wire logic [PC_W-1:0]	pc_in,
	output logic [INSTR_W-1:0]	instr_out
);
	logic [INSTR_W-1:0]	mem [32];
	// empty words read as harmless port selects
	initial foreach (mem[i]) mem[i] = '0;
	// words are loaded while the core sits in reset
	always @(posedge clk_sys_in)
		if (load_in) mem[addr_in[4:0]] <= data_in;
	// fetch is combinational from the pc
	assign instr_out = mem[pc_in[4:0]];
endmodule : rimx_prog_mem
`default_nettype wire

// ---- dv/rimx_exec_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ---------------------------
// self-checking bench
// ---------------------------
module rimx_exec_tb;
	import rimx_pkg::*;
	logic	clk_sys_in = 0, rst_b_in = 0, load = 0, en = 1, z, s;
	logic [PC_W-1:0]	pc, addr = '0;
	logic [INSTR_W-1:0]	instr, data = '0;
	logic [DATA_W-1:0]	w, p1, p2, p3;
	int	mismatches = 0, total_checks = 0, cyc = 0;
	logic [INSTR_W-1:0]	prog [20] = '{12'hc01, 12'h021, 12'h2e1, 12'hcff, 12'h2a1, 12'hc00,
		12'h222, 12'h2c1, 12'hc55, 12'hcff, 12'h023, 12'h3e3, 12'hc12, 12'h3c3, 12'h2a3,
		12'h005, 12'hc80, 12'h006, 12'h007, 12'h004};
	rimx_exec i_rimx_exec (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_en_in(en),
		.instr_in(instr), .pc_out(pc), .working_register_out(w), .zero_flag_out(z),
		.skip_cycle_out(s), .port_control_first_out(p1), .port_control_second_out(p2),
		.port_control_third_out(p3), .reg_rd_out());
	rimx_prog_mem i_rimx_prog_mem (.clk_sys_in(clk_sys_in), .load_in(load), .addr_in(addr),
		.data_in(data), .pc_in(pc), .instr_out(instr));
	// 200 mhz clock
	always #2.5 clk_sys_in = ~clk_sys_in;
	// cycle ceiling against hangs
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 400) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic cmp(string n, logic [10:0] e, logic [10:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	// wait n clock cycles, skip and disabled cycles included, then compare the core state
	task automatic run(int n, logic [10:0] epc, logic [7:0] ew, logic ez, logic es);
		repeat (n) @(posedge clk_sys_in);
		#1;
		cmp("pc", epc, pc);
		cmp("working", {3'h0, ew}, {3'h0, w});
		cmp("zero", {10'h0, ez}, {10'h0, z});
		cmp("skip", {10'h0, es}, {10'h0, s});
	endtask : run
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	// load program under reset, run it, then reset again
	initial begin
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_sys_in);
			#1 load = 1;
			addr = 11'(i);
			data = prog[i];
		end
		@(posedge clk_sys_in);
		#1 load = 0;
		repeat (3) @(posedge clk_sys_in);
		#1 rst_b_in = 1;
		run(1, 11'h001, 8'h01, 0, 0);
		run(1, 11'h002, 8'h01, 0, 0);
		run(1, 11'h003, 8'h01, 0, 1);
		run(1, 11'h004, 8'h01, 0, 0);
		run(1, 11'h005, 8'h01, 0, 0);
		run(2, 11'h007, 8'h00, 1, 0);
		run(1, 11'h008, 8'h00, 1, 1);
		run(1, 11'h009, 8'h00, 1, 0);
		run(3, 11'h00c, 8'hff, 1, 1);
		run(1, 11'h00d, 8'hff, 1, 0);
		run(1, 11'h00e, 8'h01, 1, 0);
		run(1, 11'h00f, 8'h01, 0, 0);
		run(5, 11'h014, 8'h80, 0, 0);
		// enable low: nothing may move
		en = 0;
		run(2, 11'h014, 8'h80, 0, 0);
		en = 1;
		cmp("port first", 11'h001, {3'h0, p1});
		cmp("port second", 11'h080, {3'h0, p2});
		cmp("port third", 11'h080, {3'h0, p3});
		$display("test program done");
		rst_b_in = 0;
		run(1, 11'h000, 8'h00, 0, 0);
		$display("test reset done");
		print_verdict();
	end
endmodule : rimx_exec_tb
`default_nettype wire
